/* logic/cmarm_pkg.sv */
// Package for the cell monitor converter result mux: register map,
// field positions, reset values, source codes and the converter carrier.
// Assumes byte-wide registers on an 8-bit address, one clock domain.
package cmarm_pkg;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] AUX_RESULT_HIGH_ADDR = 8'h01;
   localparam logic [7:0] FIRST_CELL_RESULT_HIGH_ADDR = 8'h03;
   localparam logic [7:0] FIRST_CELL_RESULT_LOW_ADDR = 8'h04;
   localparam logic [7:0] LAST_RESULT_LOW_ADDR = 8'h12;
   localparam logic [7:0] ADC_CONTROL_ADDR = 8'h30;
   localparam logic [7:0] FUNCTION_CONFIG_ADDR = 8'h31;
   localparam logic [7:0] CONVERT_CONTROL_ADDR = 8'h34;

   // ------------------------------------------------------------
   // Fields and reset values
   // ------------------------------------------------------------
   localparam int CELL_COUNT_LSB = 0;
   localparam int CELL_COUNT_WIDTH = 3;
   localparam int AUX_SOURCE_BIT = 4;
   localparam int AUX_REFERENCE_BIT = 6;
   localparam int CONVERT_BIT = 0;
   localparam logic [7:0] ADC_CONTROL_RESET = 8'h05;
   localparam logic [7:0] FUNCTION_CONFIG_RESET = 8'h40;
   localparam logic [2:0] CELL_COUNT_MAX = 3'h5;

   // ------------------------------------------------------------
   // Result format and converter sources
   // ------------------------------------------------------------
   localparam int RESULT_BITS = 14;
   localparam logic [15:0] FULL_CODE = 16'h3fff;
   localparam int CELL_FULL_SCALE_MV = 6250;
   localparam int NUM_PAIRS = 9;
   localparam logic [3:0] PAIR_AUX = 4'h0;
   localparam logic [3:0] PAIR_TS1 = 4'h7;
   localparam logic [3:0] PAIR_TS2 = 4'h8;

   typedef enum logic [3:0] {
      SRC_CELL1, SRC_CELL2, SRC_CELL3, SRC_CELL4, SRC_CELL5, SRC_CELL6,
      SRC_AUX_PINS, SRC_STACK, SRC_TS1, SRC_TS2
   } cmarm_source_t;

   // Request toward the converter core
   typedef struct packed {
      logic start;
      cmarm_source_t source;
      logic ref_bandgap;
   } cmarm_conv_req_t;

   // Answer from the converter core, offset-trimmed but unclamped
   typedef struct packed {
      logic done;
      logic signed [15:0] raw;
   } cmarm_conv_ans_t;

endpackage

/* logic/cmarm_result_mux.sv */
// Measurement sequencing and result formatting around the 14-bit
// converter: source selection, reference choice, clamping and the
// big-endian result register pairs behind a plain register port.
// Assumes the converter core runs on the same clock and answers each
// start with one done pulse carrying a trimmed signed raw value.
//
// Contract
// [RULE1] Results are 14-bit unsigned; the two upper word bits read zero.
// [RULE2] Converter input mux picks among six cells, two temps, one aux.
// [RULE3] Aux channel measures either aux pin pair or whole stack.
// [RULE4] Results saturate at zero and full code, never wrap.
// [RULE5] Each word sits big-endian in two bytes, high byte lower address.
// [RULE6] First cell result lives at 0x03 high and 0x04 low.
// [RULE7] Cell count field limits the scan to connected cells.
// [RULE8] Cell code 16383 means 6250 mV; codes are stored unscaled.
// [RULE9] Aux source bit routes aux pins or stack into aux result.
// [RULE10] Stack voltage is its own mux input, apart from cell inputs.
// [RULE11] Aux reference bit picks bandgap or regulator for aux pins.
// [RULE12] Stack measurement forces bandgap, ignoring the reference bit.
// [RULE13] Aux reference bit 1 is bandgap, 0 is regulator output.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps

module cmarm_result_mux (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Converter core
   output cmarm_pkg::cmarm_conv_req_t conv_req,
   input wire cmarm_pkg::cmarm_conv_ans_t conv_ans,
   // Status
   output logic busy
);

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Saturate a trimmed raw value into the 14-bit code range
   function automatic logic [13:0] clamp_code(
      input logic signed [15:0] raw);
      if (raw < 16'sd0) begin
         clamp_code = 14'h0000; // see [RULE4]
      end else if (raw > $signed(cmarm_pkg::FULL_CODE)) begin
         clamp_code = 14'h3fff; // see [RULE4]
      end else begin
         clamp_code = raw[13:0];
      end
   endfunction

   // Result pair index for a byte address: 0 aux, 1..6 cells, 7..8 temps
   function automatic logic [3:0] pair_of(input logic [7:0] addr);
      logic [7:0] offs;
      offs = addr - cmarm_pkg::AUX_RESULT_HIGH_ADDR;
      pair_of = offs[4:1]; // see [RULE5]
   endfunction

   // Sequence position to converter source, aux routed by source bit
   function automatic cmarm_pkg::cmarm_source_t source_of(
      input logic [3:0] pos, input logic stack_sel);
      if (pos < 4'h6) begin
         source_of = cmarm_pkg::cmarm_source_t'(pos); // see [RULE2]
      end else if (pos == 4'h6) begin
         // Stack is a separate mux input, not a sum of cells
         source_of = stack_sel ? cmarm_pkg::SRC_STACK // see [RULE10]
                               : cmarm_pkg::SRC_AUX_PINS; // see [RULE3]
      end else if (pos == 4'h7) begin
         source_of = cmarm_pkg::SRC_TS1;
      end else begin
         source_of = cmarm_pkg::SRC_TS2;
      end
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef enum logic [1:0] {S_IDLE, S_REQ, S_WAIT} cmarm_state_t;

   cmarm_state_t state_reg, state_next;
   logic [3:0] pos_reg, pos_next;
   logic [7:0] adc_control_reg;
   logic [7:0] function_config_reg;
   logic [7:0] rdata_reg;
   logic [13:0] result_mem [0:cmarm_pkg::NUM_PAIRS-1];
   cmarm_pkg::cmarm_conv_req_t req_reg, req_next;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire logic [2:0] cell_count_raw;
   wire logic [2:0] cell_last;
   wire logic aux_stack_sel;
   wire logic aux_ref_bandgap;
   wire logic wr_adc_control;
   wire logic wr_function_config;
   wire logic wr_convert;
   wire logic start_scan;
   wire logic in_result_range;
   wire logic [3:0] rd_pair;
   wire logic rd_high;
   wire logic [15:0] rd_word;
   wire logic [7:0] rd_value;
   wire logic [3:0] store_pair;
   wire logic [3:0] pos_after;
   wire logic scan_end;
   wire logic [13:0] clamped;
   wire cmarm_pkg::cmarm_source_t next_source;
   wire logic next_ref;

   // Control fields; out-of-range cell counts act as six cells
   assign cell_count_raw = adc_control_reg[cmarm_pkg::CELL_COUNT_LSB +:
                                           cmarm_pkg::CELL_COUNT_WIDTH];
   assign cell_last = (cell_count_raw > cmarm_pkg::CELL_COUNT_MAX) ?
                      cmarm_pkg::CELL_COUNT_MAX : cell_count_raw;
   assign aux_stack_sel = function_config_reg[cmarm_pkg::AUX_SOURCE_BIT];
   assign aux_ref_bandgap =
      function_config_reg[cmarm_pkg::AUX_REFERENCE_BIT];

   // Write strobes; a start while busy is dropped on purpose
   assign wr_adc_control = reg_wr &&
      (reg_addr == cmarm_pkg::ADC_CONTROL_ADDR);
   assign wr_function_config = reg_wr &&
      (reg_addr == cmarm_pkg::FUNCTION_CONFIG_ADDR);
   assign wr_convert = reg_wr &&
      (reg_addr == cmarm_pkg::CONVERT_CONTROL_ADDR);
   assign start_scan = wr_convert && reg_wdata[cmarm_pkg::CONVERT_BIT] &&
      (state_reg == S_IDLE);

   // Read path: result pairs big-endian, control bytes, zero elsewhere
   assign in_result_range = (reg_addr >= cmarm_pkg::AUX_RESULT_HIGH_ADDR)
      && (reg_addr <= cmarm_pkg::LAST_RESULT_LOW_ADDR);
   assign rd_pair = pair_of(reg_addr);
   assign rd_high = reg_addr[0]; // see [RULE5]
   assign rd_word = {2'b00, result_mem[rd_pair]}; // see [RULE1]
   assign rd_value =
      in_result_range ? (rd_high ? rd_word[15:8] : rd_word[7:0]) :
      (reg_addr == cmarm_pkg::ADC_CONTROL_ADDR) ? adc_control_reg :
      (reg_addr == cmarm_pkg::FUNCTION_CONFIG_ADDR) ? function_config_reg :
      (reg_addr == cmarm_pkg::CONVERT_CONTROL_ADDR) ?
         {7'h00, busy} : 8'h00;

   // Sequence stepping; cells above the count are skipped
   assign store_pair = (pos_reg < 4'h6) ? pos_reg + 4'h1 : // see [RULE6]
                       (pos_reg == 4'h6) ? cmarm_pkg::PAIR_AUX :
                       (pos_reg == 4'h7) ? cmarm_pkg::PAIR_TS1 :
                       cmarm_pkg::PAIR_TS2;
   assign pos_after = (pos_reg == {1'b0, cell_last}) ? 4'h6 : // see [RULE7]
                      pos_reg + 4'h1;
   assign scan_end = (pos_reg == 4'h8);
   assign clamped = clamp_code(conv_ans.raw); // see [RULE4]

   // Reference: cells and stack on bandgap, temps on regulator
   assign next_source = source_of(start_scan ? 4'h0 : pos_after,
                                  aux_stack_sel); // see [RULE9]
   assign next_ref =
      (next_source == cmarm_pkg::SRC_STACK) ? 1'b1 : // see [RULE12]
      (next_source == cmarm_pkg::SRC_AUX_PINS) ?
         aux_ref_bandgap : // see [RULE11] see [RULE13]
      (next_source == cmarm_pkg::SRC_TS1 ||
       next_source == cmarm_pkg::SRC_TS2) ? 1'b0 : 1'b1;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Next state; one request per source, waits for done
   always_comb begin
      state_next = state_reg;
      pos_next = pos_reg;
      req_next = req_reg;
      req_next.start = 1'b0;
      unique case (state_reg)
         S_IDLE: begin
            if (start_scan) begin
               state_next = S_REQ;
               pos_next = 4'h0;
               req_next.source = next_source;
               req_next.ref_bandgap = next_ref;
            end
         end
         S_REQ: begin
            req_next.start = 1'b1;
            state_next = S_WAIT;
         end
         S_WAIT: begin
            if (conv_ans.done) begin
               if (scan_end) begin
                  state_next = S_IDLE;
               end else begin
                  state_next = S_REQ;
                  pos_next = pos_after;
                  req_next.source = next_source;
                  req_next.ref_bandgap = next_ref;
               end
            end
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg <= S_IDLE;
         pos_reg <= 4'h0;
         req_reg <= '0;
         busy <= 1'b0;
      end else begin
         state_reg <= state_next;
         pos_reg <= pos_next;
         req_reg <= req_next;
         busy <= (state_next != S_IDLE);
      end
   end

   assign conv_req = req_reg;

   // ------------------------------------------------------------
   // Registers and results
   // ------------------------------------------------------------
   // Config bytes; a write mid-scan affects only later sources
   always_ff @(posedge clock) begin
      if (rst) begin
         adc_control_reg <= cmarm_pkg::ADC_CONTROL_RESET;
         function_config_reg <= cmarm_pkg::FUNCTION_CONFIG_RESET;
         rdata_reg <= 8'h00;
      end else begin
         if (wr_adc_control) begin
            adc_control_reg <= reg_wdata;
         end
         if (wr_function_config) begin
            function_config_reg <= reg_wdata;
         end
         if (reg_rd) begin
            rdata_reg <= rd_value;
         end
      end
   end

   assign reg_rdata = rdata_reg;

   // Result store; raw codes kept, scaling left to software
   generate
      for (genvar i = 0; i < cmarm_pkg::NUM_PAIRS; i++) begin : g_res
         always_ff @(posedge clock) begin
            if (rst) begin
               result_mem[i] <= 14'h0000;
            end else if (state_reg == S_WAIT && conv_ans.done &&
                         store_pair == 4'(i)) begin
               result_mem[i] <= clamped; // see [RULE8]
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // One clock domain; reset masks every check
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   a_upper_bits_zero: assert property ( // see [RULE1]
      reg_rd && in_result_range && reg_addr[0] |=> reg_rdata[7:6] == 2'b00)
      else $error("result high byte upper bits not zero");

   a_clamp_saturates: assert property ( // see [RULE4]
      (conv_ans.raw < 16'sd0 |-> clamped == 14'h0000) and
      (conv_ans.raw > 16'sd16383 |-> clamped == 14'h3fff))
      else $error("result not saturated");

   a_first_cell_pair: assert property ( // see [RULE6]
      reg_rd && reg_addr == cmarm_pkg::FIRST_CELL_RESULT_HIGH_ADDR
      |=> reg_rdata == {2'b00, $past(result_mem[1][13:8])})
      else $error("first cell high byte wrong");

   a_low_byte_order: assert property ( // see [RULE5]
      reg_rd && reg_addr == cmarm_pkg::FIRST_CELL_RESULT_LOW_ADDR
      |=> reg_rdata == $past(result_mem[1][7:0]))
      else $error("first cell low byte wrong");

   a_stored_unscaled: assert property ( // see [RULE8]
      state_reg == S_WAIT && conv_ans.done && pos_reg == 4'h0
      |=> result_mem[1] == $past(clamped))
      else $error("cell code not stored as converted");

   a_scan_limit: assert property ( // see [RULE7]
      conv_req.start && conv_req.source < cmarm_pkg::SRC_AUX_PINS
      |-> conv_req.source <= {1'b0, cell_last})
      else $error("cell beyond count scanned");

   a_source_legal: assert property ( // see [RULE2]
      conv_req.start |-> conv_req.source <= cmarm_pkg::SRC_TS2)
      else $error("illegal converter source");

   a_aux_routing: assert property ( // see [RULE9]
      conv_req.start && pos_reg == 4'h6 |-> conv_req.source ==
      ($past(aux_stack_sel, 2) ? cmarm_pkg::SRC_STACK :
       cmarm_pkg::SRC_AUX_PINS))
      else $error("aux source not routed by select bit");

   // Aux slot never borrows a cell or temperature input
   a_aux_two_sources: assert property ( // see [RULE3]
      conv_req.start && pos_reg == 4'h6 |->
      conv_req.source inside {cmarm_pkg::SRC_AUX_PINS, cmarm_pkg::SRC_STACK})
      else $error("aux slot measured another source");

   a_stack_bandgap: assert property ( // see [RULE12]
      conv_req.start && conv_req.source == cmarm_pkg::SRC_STACK
      |-> conv_req.ref_bandgap)
      else $error("stack measured without bandgap");

   // Reference is latched two edges before the start pulse is sampled
   a_aux_reference: assert property ( // see [RULE13]
      conv_req.start && conv_req.source == cmarm_pkg::SRC_AUX_PINS
      |-> conv_req.ref_bandgap == $past(aux_ref_bandgap, 2))
      else $error("aux reference bit not followed");

   // Temperature dividers hang off the regulator, so stay ratiometric
   a_temp_regulator: assert property ( // see [RULE2]
      conv_req.start && (conv_req.source == cmarm_pkg::SRC_TS1 ||
      conv_req.source == cmarm_pkg::SRC_TS2) |-> !conv_req.ref_bandgap)
      else $error("temperature measured on bandgap");

   a_start_timing: assert property (
      start_scan |=> busy ##1 conv_req.start)
      else $error("scan did not start in two cycles");

   // Convert byte reads back the scan-running flag
   a_busy_readback: assert property (
      reg_rd && reg_addr == cmarm_pkg::CONVERT_CONTROL_ADDR
      |=> reg_rdata == {7'h00, $past(busy)})
      else $error("convert byte does not show busy");

   // Main scenarios: full scan, stack, clamping, aux on regulator
   c_six_cell_scan: cover property (
      conv_req.start && conv_req.source == cmarm_pkg::SRC_CELL6);
   c_stack_measured: cover property (
      conv_req.start && conv_req.source == cmarm_pkg::SRC_STACK);
   c_low_clamp: cover property (
      state_reg == S_WAIT && conv_ans.done && conv_ans.raw < 16'sd0);
   c_scan_done: cover property (busy ##1 !busy);
   c_aux_regulator: cover property (
      conv_req.start && conv_req.source == cmarm_pkg::SRC_AUX_PINS &&
      !conv_req.ref_bandgap);

endmodule // cmarm_result_mux

/* sim/cmarm_conv_model.sv */
// Behavioural converter core facing the result mux: answers each start
// with one done pulse after a set delay, taking raw codes from a table.
// Assumes one clock shared with the mux and a table set by the bench.
`timescale 1ns/1ps

module cmarm_conv_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Converter request and answer
   input wire cmarm_pkg::cmarm_conv_req_t conv_req,
   output cmarm_pkg::cmarm_conv_ans_t conv_ans,
   // Scenario control
   input wire logic [3:0] delay,
   input wire logic signed [15:0] raw_table [10],
   input wire logic clear,
   // Observation of requests
   output logic [7:0] conv_count,
   output logic [9:0] src_mask,
   output logic [9:0] ref_seen
);
   logic pending;
   logic [3:0] wait_cnt;
   logic [3:0] src_held;

   // Raw bus flips every idle cycle so a stale value never matches
   always_ff @(posedge clock) begin
      conv_ans.done <= 1'b0;
      conv_ans.raw <= ~conv_ans.raw;
      if (rst) begin
         conv_ans <= '0;
         pending <= 1'b0;
         wait_cnt <= 4'h0;
         src_held <= 4'h0;
      end else if (conv_req.start) begin
         pending <= 1'b1;
         wait_cnt <= delay;
         src_held <= conv_req.source;
         conv_count <= conv_count + 8'h01;
         src_mask[conv_req.source] <= 1'b1;
         ref_seen[conv_req.source] <= conv_req.ref_bandgap;
      end else if (pending) begin
         if (wait_cnt <= 4'h1) begin
            conv_ans.done <= 1'b1;
            conv_ans.raw <= raw_table[src_held];
            pending <= 1'b0;
         end else begin
            wait_cnt <= wait_cnt - 4'h1;
         end
      end
      // Observation is cleared between scans and by the reset shared with the mux
      if (rst || clear) begin
         conv_count <= 8'h00;
         src_mask <= 10'h000;
         ref_seen <= 10'h000;
      end
   end
endmodule // cmarm_conv_model

/* sim/testbench.sv */
// Testbench for the converter result mux: register tasks, scans and
// expected results worked out from the clamping and layout rules.
// Assumes cmarm_conv_model stands in for the converter core.
`timescale 1ns/1ps

module testbench;
   // ------------------------------------------------------------
   // Signals and instances
   // ------------------------------------------------------------
   logic clock, rst, reg_wr, reg_rd, busy, clear;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, hi, lo;
   logic [3:0] delay;
   logic signed [15:0] tbl [10];
   logic [15:0] exp_pair [9];
   logic [7:0] conv_count;
   logic [9:0] src_mask, ref_seen;
   cmarm_pkg::cmarm_conv_req_t conv_req;
   cmarm_pkg::cmarm_conv_ans_t conv_ans;
   int failures, comparisons;

   cmarm_result_mux cmarm_result_mux_inst (.clock(clock), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_req(conv_req),
      .conv_ans(conv_ans), .busy(busy));

   cmarm_conv_model cmarm_conv_model_inst (.clock(clock), .rst(rst),
      .conv_req(conv_req), .conv_ans(conv_ans), .delay(delay),
      .raw_table(tbl), .clear(clear), .conv_count(conv_count),
      .src_mask(src_mask), .ref_seen(ref_seen));

   // Free-running 100 MHz clock
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      comparisons++;
      if (seen !== expv) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expv);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // Data appear in the cycle after the strobe and hold until the next read, so sample there
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [7:0] expv);
      logic [7:0] d;
      rd(a, d);
      check({8'h00, d}, {8'h00, expv});
   endtask

   function automatic logic [15:0] clampv(input logic signed [15:0] r);
      if (r < 0) return 16'h0000;
      if (r > 16'sd16383) return 16'h3fff;
      return r;
   endfunction

   // Only the cells scanned this time get new expectations
   task automatic set_expect(input int aux_idx, input int ncells);
      exp_pair[0] = clampv(tbl[aux_idx]);
      for (int i = 1; i <= ncells; i++) begin
         exp_pair[i] = clampv(tbl[i - 1]);
      end
      exp_pair[7] = clampv(tbl[8]);
      exp_pair[8] = clampv(tbl[9]);
   endtask

   task automatic check_pairs();
      for (int i = 0; i < 9; i++) begin
         rd(8'(1 + 2 * i), hi);
         rd(8'(2 + 2 * i), lo);
         check({hi, lo}, exp_pair[i]);
      end
   endtask

   // Start a scan, retry the start while busy, wait bounded for idle
   task automatic scan(input logic [7:0] n);
      int k;
      @(posedge clock);
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
      wr(8'h34, 8'h01);
      rd_check(8'h34, 8'h01);
      wr(8'h34, 8'h01);
      k = 0;
      while (busy !== 1'b0 && k < 3000) begin
         @(posedge clock);
         #1;
         k++;
      end
      if (k >= 3000) failures++;
      check(16'(conv_count), 16'(n));
   endtask

   task automatic results();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #500000;
      failures++;
      results();
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      clear = 1'b0;
      delay = 4'h1;
      failures = 0;
      comparisons = 0;
      tbl = '{16'sh224d, -16'sd5, 16'sd16390, 16'sd16383, 16'sh0000,
         16'sh1234, 16'sh2000, 16'sh26f7, 16'sh1116, 16'sh7fff};
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rd_check(8'h30, 8'h05);
      rd_check(8'h31, 8'h40);
      rd_check(8'h03, 8'h00);
      rd_check(8'h20, 8'h00);
      $display("test reset values done");
      // Six cells, aux pins on bandgap, prompt converter
      scan(8'd9);
      check(16'(src_mask), 16'h037f);
      check(16'(ref_seen), 16'h007f);
      set_expect(6, 6);
      check_pairs();
      rd_check(8'h03, 8'h22);
      rd_check(8'h04, 8'h4d);
      rd(8'h03, hi);
      rd(8'h04, lo);
      check(16'(int'({hi, lo}) * 6250 / 16383), 16'd3349);
      wr(8'h03, 8'hff);
      rd_check(8'h03, 8'h22);
      $display("test six cell scan done");
      // Three cells, stack on aux with reference bit low, slow converter
      wr(8'h30, 8'h02);
      wr(8'h31, 8'h10);
      tbl[3] <= 16'sh0100;
      tbl[4] <= 16'sh0100;
      tbl[5] <= 16'sh0100;
      delay <= 4'h7;
      scan(8'd6);
      check(16'(src_mask), 16'h0387);
      check(16'(ref_seen), 16'h0087);
      set_expect(7, 3);
      check_pairs();
      $display("test stack scan done");
      // One cell, aux pins on regulator reference
      wr(8'h30, 8'h00);
      wr(8'h31, 8'h00);
      tbl[6] <= 16'sh0800;
      delay <= 4'h1;
      scan(8'd4);
      check(16'(src_mask), 16'h0341);
      check(16'(ref_seen), 16'h0001);
      set_expect(6, 1);
      check_pairs();
      $display("test one cell scan done");
      // Cell count seven acts as six
      wr(8'h30, 8'h07);
      scan(8'd9);
      check(16'(src_mask), 16'h0341 | 16'h003e);
      $display("test count seven done");
      results();
   end
endmodule // testbench
